//--- bench/aac_ctrl_tb_top.sv
/*
 * Self-checking bench for the auxiliary converter sequencer: register access,
 * divider ratios, conversion timing and results, soft reset and interrupt.
 * Assumes the Wishbone slave acks every request and that ce_i may stay high.
 */
`timescale 1ns/1ps
`default_nettype none
`include "aac_cfg.svh"

module aac_ctrl_tb_top;
    import aac_pkg::*;

    // =========================================================================
    // Design hookup
    localparam logic [9:0] A_SETUP = {`AAC_IDX_SETUP, 2'b00};
    localparam logic [9:0] A_HI = {`AAC_IDX_RES_HI, 2'b00};
    localparam logic [9:0] A_LO = {`AAC_IDX_RES_LO, 2'b00};
    localparam logic [9:0] A_C0 = {`AAC_IDX_CTRL0, 2'b00};
    localparam logic [9:0] A_C1 = {`AAC_IDX_CTRL1, 2'b00};
    localparam logic [9:0] A_STAT = {`AAC_IDX_IRQ_STAT, 2'b00};
    localparam logic [9:0] A_MASK = {`AAC_IDX_IRQ_MASK, 2'b00};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ce_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [9:0] wb_adr_i = 10'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    aac_result_t conversion_result_i = 12'h000;
    aac_chan_t input_channel_select_o;
    logic converter_clock_o;
    logic conversion_start_o;
    logic converter_reset_o;
    logic temp_sensor_enable_o;
    logic [2:0] reference_trim_o;
    logic irq_o;
    int num_errors = 0;
    int checks = 0;
    int rises = 0;
    int starts = 0;
    int resets = 0;
    int ncyc = 0;
    int last_rise = 0;
    int period = 0;
    logic ck_q = 1'b0;
    logic [31:0] rd;
    int lens [4] = '{20, 22, 26, 34};

    aac_ctrl #(.AW(10)) u_aac_ctrl (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .conversion_result_i(conversion_result_i),
        .input_channel_select_o(input_channel_select_o),
        .converter_clock_o(converter_clock_o),
        .conversion_start_o(conversion_start_o),
        .converter_reset_o(converter_reset_o),
        .temp_sensor_enable_o(temp_sensor_enable_o),
        .reference_trim_o(reference_trim_o), .irq_o(irq_o)
    );

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    // Counts converter clock rises, their spacing and the output pulses.
    always @(posedge clk_i) begin
        ck_q <= converter_clock_o;
        ncyc <= ncyc + 1;
        if (converter_clock_o === 1'b1 && ck_q === 1'b0) begin
            rises <= rises + 1;
            period <= ncyc - last_rise;
            last_rise <= ncyc;
        end
        if (conversion_start_o === 1'b1) starts <= starts + 1;
        if (converter_reset_o === 1'b1) resets <= resets + 1;
    end

    // =========================================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [9:0] adr, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) check(32'h0, 32'h1, "ack timeout");
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        // Lets the write settle so that callers see the updated outputs.
        @(posedge clk_i);
    endtask

    task automatic rchk(input logic [9:0] adr, input logic [7:0] exp, input string what);
        wb(1'b0, adr, 8'h00);
        check(rd, {24'h000000, exp}, what);
    endtask

    task automatic wait_rises(input int n);
        int t;
        t = rises + n;
        repeat (3000) if (rises < t) @(posedge clk_i);
        if (rises < t) check(32'h0, 32'h1, "converter clock stalled");
    endtask

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_i);
        num_errors++;
        $display("Watchdog expired");
        test_done();
    end

    // =========================================================================
    // Tests
    initial begin
        int n;
        logic [1:0] len;
        logic [2:0] ch;
        aac_result_t res;
        aac_result_t prev;
        logic [2:0] pch;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (lens[i]) rchk(A_SETUP + 10'(4 * i), 8'h00, "reset value");
        rchk(10'h3FC, 8'h00, "unmapped read");
        $display("reset values test done");

        wb(1'b1, A_C1, 8'hFF);
        rchk(A_C1, 8'h9C, "ctrl1 readback");
        wb(1'b1, A_C1, 8'h8C);
        check(32'(temp_sensor_enable_o), 32'h1, "sensor enable");
        check(32'(reference_trim_o), 32'h3, "trim out");
        wb(1'b1, A_C1, 8'h08);
        check(32'(temp_sensor_enable_o), 32'h0, "sensor off");
        check(32'(reference_trim_o), 32'h2, "trim out");
        $display("control outputs test done");

        for (int c = 0; c < 8; c++) begin
            wb(1'b1, A_C0, {5'b10111, 3'(c)});
            rchk(A_C0, {5'b10000, 3'(c)}, "ctrl0 readback");
            wait_rises(3);
            check(32'(period), 32'(2 ** (8 - c)), "divide ratio");
        end
        wb(1'b1, A_C0, 8'h04);
        repeat (2) @(posedge clk_i);
        n = rises;
        repeat (40) @(posedge clk_i);
        check(32'(rises - n), 32'h0, "gated clock");
        check(32'(converter_clock_o), 32'h0, "gated level");
        $display("divider test done");

        wb(1'b1, A_C0, 8'h84);
        wb(1'b1, A_MASK, 8'h01);
        prev = 12'h000;
        pch = 3'h0;
        for (int i = 0; i < 8; i++) begin
            len = 2'(i % 4);
            ch = 3'(i);
            res = 12'h9C3 ^ 12'(i * 12'h111);
            conversion_result_i <= res;
            wait_rises(1);
            n = starts;
            wb(1'b1, A_SETUP, {len, 3'b111, ch});
            @(posedge clk_i);
            @(posedge clk_i);
            check(32'(starts - n), 32'h1, "start pulse");
            check(32'(input_channel_select_o), 32'(ch), "channel route");
            rchk(A_SETUP, {len, 3'b000, ch}, "setup readback");
            wait_rises(lens[len] - 2);
            rchk(A_LO, {prev[3:0], 1'b0, pch}, "done clear");
            wait_rises(2);
            repeat (2) @(posedge clk_i);
            rchk(A_HI, res[11:4], "result high");
            rchk(A_LO, {res[3:0], 1'b1, ch}, "result low");
            check(32'(irq_o), 32'h1, "irq raised");
            rchk(A_STAT, 8'h01, "status done");
            check(32'(irq_o), 32'h0, "irq cleared");
            prev = res;
            pch = ch;
        end
        wb(1'b1, A_HI, 8'h00);
        rchk(A_HI, res[11:4], "read-only high");
        $display("conversion test done");

        wb(1'b1, A_MASK, 8'h00);
        wait_rises(1);
        wb(1'b1, A_SETUP, 8'h05);
        wait_rises(20);
        repeat (2) @(posedge clk_i);
        check(32'(irq_o), 32'h0, "masked irq");
        rchk(A_STAT, 8'h01, "masked status");
        $display("mask test done");

        ce_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        n = rises;
        repeat (40) @(posedge clk_i);
        check(32'(rises - n), 32'h0, "frozen by clock enable");
        ce_i <= 1'b1;
        $display("clock enable test done");

        wb(1'b1, A_SETUP, 8'hC6);
        wait_rises(3);
        n = resets;
        wb(1'b1, A_C0, 8'hC4);
        repeat (2) @(posedge clk_i);
        check(32'(resets - n), 32'h1, "reset pulse");
        rchk(A_LO, 8'h00, "reset clears");
        rchk(A_HI, 8'h00, "reset clears");
        wb(1'b1, A_C0, 8'hC4);
        repeat (2) @(posedge clk_i);
        check(32'(resets - n), 32'h1, "level no retrigger");
        wb(1'b1, A_C0, 8'h84);
        wb(1'b1, A_C0, 8'hC4);
        repeat (2) @(posedge clk_i);
        check(32'(resets - n), 32'h2, "second reset");
        rchk(A_STAT, 8'h02, "reset status");
        $display("soft reset test done");
        test_done();
    end

endmodule // aac_ctrl_tb_top

`default_nettype wire

//--- design/aac_clkdiv.sv
/*
 * Converter clock divider: makes a square converter clock from the main
 * clock and a one-cycle pulse in the cycle in which it rises.
 * Assumes run_i stops the clock low and that div_code_i comes from a register.
 */
`timescale 1ns/1ps
`default_nettype none
`include "aac_cfg.svh"

module aac_clkdiv
    import aac_pkg::*;
#(
    parameter int CW = 7
) (
    // Clock, reset and clock enable.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Control.
    input wire logic run_i,
    input wire logic [2:0] div_code_i,
    // Divided clock and its rising-edge marker.
    output logic converter_clock_o,
    output logic rise_o
);

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic [CW-1:0] term;
    logic [CW:0] half;
    logic next_clk;
    logic next_rise;

    // =========================================================================
    // Half period is two to the power seven minus the code.
    assign half = (CW+1)'(1) << (`AAC_DIV_EXP - div_code_i); // see RULE_11 see RULE_16
    assign term = CW'(half - (CW+1)'(1));

    always_comb begin
        next_cnt = cnt;
        next_clk = converter_clock_o;
        next_rise = 1'b0;
        if (!run_i) begin
            next_cnt = '0;
            next_clk = 1'b0; // see RULE_08
        end else if (cnt >= term) begin
            next_cnt = '0;
            next_clk = !converter_clock_o;
            next_rise = !converter_clock_o;
        end else begin
            next_cnt = cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= '0;
            converter_clock_o <= 1'b0;
            rise_o <= 1'b0;
        end else if (ce_i) begin
            cnt <= next_cnt;
            converter_clock_o <= next_clk;
            rise_o <= next_rise;
        end
    end

    // =========================================================================
    // Checking helpers: main-clock cycles between two rises at a steady code.
    logic [8:0] gap;
    logic seen;
    logic [2:0] hcode;

    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            gap <= 9'h000;
            seen <= 1'b0;
            hcode <= 3'h0;
        end else if (ce_i) begin
            hcode <= div_code_i;
            gap <= rise_o ? 9'h001 : gap + 9'h001;
            if (div_code_i != hcode) begin
                seen <= 1'b0;
            end else if (rise_o) begin
                seen <= 1'b1;
            end
        end
    end

    a_div_ratio: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i) // see RULE_11
        rise_o && seen && div_code_i == hcode && run_i |-> gap == {half, 1'b0})
        else $error("converter clock period does not match the divider code");

endmodule // aac_clkdiv

`default_nettype wire

//--- design/aac_ctrl.sv
/*
 * Auxiliary converter sequencer: Wishbone register slave, conversion timing,
 * result capture, soft reset, sensor and reference controls and interrupt.
 * Assumes the analog core presents a settled result on conversion_result_i
 * by the last converter clock rise of a conversion.
 */
`timescale 1ns/1ps
`default_nettype none
`include "aac_cfg.svh"

// =============================================================================
// Summary of operation
// RULE_01: Length code selects 20, 22, 26, 34 cycles.
// RULE_02: Channel field routes one of eight inputs.
// RULE_03: Any setup register write starts a conversion.
// RULE_04: Result high register shows result bits 11:4.
// RULE_05: Result low nibble sits in status bits 7:4.
// RULE_06: Done bit reads 0 running, 1 valid.
// RULE_07: Status bits 2:0 echo converted channel.
// RULE_08: Clock enable bit gates the converter clock.
// RULE_09: Soft reset fires on rising bit only.
// RULE_10: Software clears soft reset bit afterwards.
// RULE_11: Divider code sets converter clock ratio.
// RULE_12: Software keeps converter clock below 10 MHz.
// RULE_13: Conversion lasts exactly the configured cycles.
// RULE_14: Control bit drives temperature sensor enable.
// RULE_15: Trim field is held and driven out.
// RULE_16: Middle divider codes keep halving the ratio.
// RULE_17: Start clears done; results update together.
// RULE_18: Unused bits read zero, ignore writes.
module aac_ctrl
    import aac_pkg::*;
#(
    parameter int AW = 10
) (
    // Clock, reset and clock enable.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [AW-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Analog converter core.
    input wire aac_result_t conversion_result_i,
    output aac_chan_t input_channel_select_o,
    output logic converter_clock_o,
    output logic conversion_start_o,
    output logic converter_reset_o,
    output logic temp_sensor_enable_o,
    output logic [2:0] reference_trim_o,
    // Interrupt.
    output logic irq_o
);

    // =========================================================================
    // Bus decode. A request takes effect at the edge where ack is seen high.
    logic req;
    logic take_wr;
    logic take_rd;
    logic [7:0] idx;

    assign req = wb_cyc_i & wb_stb_i;
    assign idx = 8'(wb_adr_i[AW-1:2]);
    assign take_wr = req & wb_ack_o & wb_we_i & wb_sel_i[0];
    assign take_rd = req & wb_ack_o & !wb_we_i;

    // =========================================================================
    // State.
    aac_state_t state;
    aac_state_t next_state;
    logic [1:0] cfg_len;
    logic [1:0] next_cfg_len;
    aac_chan_t next_ch;
    logic clk_en;
    logic next_clk_en;
    logic srst_bit;
    logic next_srst_bit;
    logic [2:0] div_code;
    logic [2:0] next_div_code;
    logic next_temp;
    logic [2:0] next_trim;
    aac_result_t result;
    aac_result_t next_result;
    logic done;
    logic next_done;
    aac_chan_t echo;
    aac_chan_t next_echo;
    logic [5:0] cyc_cnt;
    logic [5:0] next_cyc_cnt;
    logic next_start;
    logic next_reset;
    logic [`AAC_IRQ_W-1:0] irq_stat;
    logic [`AAC_IRQ_W-1:0] next_irq_stat;
    logic [`AAC_IRQ_W-1:0] irq_mask;
    logic [`AAC_IRQ_W-1:0] next_irq_mask;
    logic [`AAC_IRQ_W-1:0] events;
    logic next_irq;
    logic [31:0] next_dat;
    logic next_ack;
    logic tick;

    function automatic logic [5:0] conv_len(input logic [1:0] code);
        unique case (code)
            2'h0: conv_len = `AAC_LEN_0; // see RULE_01
            2'h1: conv_len = `AAC_LEN_1;
            2'h2: conv_len = `AAC_LEN_2;
            2'h3: conv_len = `AAC_LEN_3;
        endcase
    endfunction

    // =========================================================================
    // Converter clock.
    aac_clkdiv #(
        .CW(7)
    ) u_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .run_i(clk_en), // see RULE_08
        .div_code_i(div_code), // see RULE_11
        .converter_clock_o(converter_clock_o),
        .rise_o(tick)
    );

    // =========================================================================
    // Bus answer: ack one cycle after the request, read data with it.
    always_comb begin
        next_ack = req & !wb_ack_o;
        next_dat = wb_dat_o;
        if (req & !wb_ack_o) begin
            next_dat = 32'h0000_0000; // see RULE_18
            if (!wb_we_i) begin
                case (idx)
                    `AAC_IDX_SETUP: next_dat[7:0] = {cfg_len, 3'h0, input_channel_select_o};
                    `AAC_IDX_RES_HI: next_dat[7:0] = result[`AAC_RESHI_RES]; // see RULE_04
                    `AAC_IDX_RES_LO: begin
                        next_dat[7:0] = {result[`AAC_RESLO_RES], done, echo}; // see RULE_05
                    end
                    `AAC_IDX_CTRL0: next_dat[7:0] = {clk_en, srst_bit, 3'h0, div_code};
                    `AAC_IDX_CTRL1: begin
                        next_dat[7:0] = {temp_sensor_enable_o, 2'h0, reference_trim_o, 2'h0};
                    end
                    `AAC_IDX_IRQ_STAT: next_dat[`AAC_IRQ_W-1:0] = irq_stat;
                    `AAC_IDX_IRQ_MASK: next_dat[`AAC_IRQ_W-1:0] = irq_mask;
                    default: next_dat = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    // =========================================================================
    // Configuration, sequencing and result capture.
    always_comb begin
        next_state = state;
        next_cfg_len = cfg_len;
        next_ch = input_channel_select_o;
        next_clk_en = clk_en;
        next_srst_bit = srst_bit;
        next_div_code = div_code;
        next_temp = temp_sensor_enable_o;
        next_trim = reference_trim_o;
        next_result = result;
        next_done = done;
        next_echo = echo;
        next_cyc_cnt = cyc_cnt;
        next_start = 1'b0;
        next_reset = 1'b0;
        events = '0;
        // Count converter clock rises; the last one closes the conversion.
        if (state == AAC_CONVERT && tick) begin
            if (cyc_cnt == conv_len(cfg_len) - 6'h01) begin // see RULE_13
                next_state = AAC_IDLE;
                next_result = conversion_result_i; // see RULE_17
                next_echo = input_channel_select_o; // see RULE_07
                next_done = 1'b1; // see RULE_06
                events[`AAC_IRQ_DONE] = 1'b1;
            end else begin
                next_cyc_cnt = cyc_cnt + 6'h01;
            end
        end
        if (take_wr) begin
            case (idx)
                `AAC_IDX_SETUP: begin
                    next_cfg_len = wb_dat_i[`AAC_SETUP_LEN]; // see RULE_01
                    next_ch = wb_dat_i[`AAC_SETUP_CH]; // see RULE_02
                    next_state = AAC_CONVERT; // see RULE_03
                    next_cyc_cnt = 6'h00;
                    next_done = 1'b0; // see RULE_17
                    next_start = 1'b1;
                end
                `AAC_IDX_CTRL0: begin
                    next_clk_en = wb_dat_i[`AAC_CTRL0_CLKEN]; // see RULE_08
                    next_srst_bit = wb_dat_i[`AAC_CTRL0_SRST];
                    next_div_code = wb_dat_i[`AAC_CTRL0_DIV]; // see RULE_11
                    if (wb_dat_i[`AAC_CTRL0_SRST] && !srst_bit) begin // see RULE_09
                        next_reset = 1'b1;
                        next_state = AAC_IDLE;
                        next_cyc_cnt = 6'h00;
                        next_done = 1'b0;
                        next_result = `AAC_RST_RESULT;
                        next_echo = `AAC_RST_CH;
                        events[`AAC_IRQ_SRST] = 1'b1;
                    end
                end
                `AAC_IDX_CTRL1: begin
                    next_temp = wb_dat_i[`AAC_CTRL1_TEMP]; // see RULE_14
                    next_trim = wb_dat_i[`AAC_CTRL1_TRIM]; // see RULE_15
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= AAC_IDLE;
            cfg_len <= `AAC_RST_LEN;
            input_channel_select_o <= `AAC_RST_CH;
            clk_en <= 1'b0;
            srst_bit <= 1'b0;
            div_code <= `AAC_RST_DIV;
            temp_sensor_enable_o <= 1'b0;
            reference_trim_o <= `AAC_RST_TRIM;
            result <= `AAC_RST_RESULT;
            done <= 1'b0;
            echo <= `AAC_RST_CH;
            cyc_cnt <= 6'h00;
            conversion_start_o <= 1'b0;
            converter_reset_o <= 1'b0;
        end else if (ce_i) begin
            state <= next_state;
            cfg_len <= next_cfg_len;
            input_channel_select_o <= next_ch;
            clk_en <= next_clk_en;
            srst_bit <= next_srst_bit;
            div_code <= next_div_code;
            temp_sensor_enable_o <= next_temp;
            reference_trim_o <= next_trim;
            result <= next_result;
            done <= next_done;
            echo <= next_echo;
            cyc_cnt <= next_cyc_cnt;
            conversion_start_o <= next_start;
            converter_reset_o <= next_reset;
        end
    end

    // =========================================================================
    // Interrupt: sticky status, cleared by reading it; an event wins.
    always_comb begin
        next_irq_mask = irq_mask;
        next_irq_stat = irq_stat;
        if (take_wr && idx == `AAC_IDX_IRQ_MASK) begin
            next_irq_mask = wb_dat_i[`AAC_IRQ_W-1:0];
        end
        if (take_rd && idx == `AAC_IDX_IRQ_STAT) begin
            next_irq_stat = irq_stat & ~wb_dat_o[`AAC_IRQ_W-1:0];
        end
        next_irq_stat = next_irq_stat | events;
        next_irq = |(next_irq_stat & next_irq_mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_stat <= `AAC_RST_IRQ;
            irq_mask <= `AAC_RST_IRQ;
            irq_o <= 1'b0;
        end else if (ce_i) begin
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            irq_o <= next_irq;
        end
    end

    // =========================================================================
    // Checks.
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i || !ce_i);

    logic [5:0] rises;

    always_ff @(posedge clk_i) begin
        if (rst_i || (ce_i && next_start)) begin
            rises <= 6'h00;
        end else if (ce_i && state == AAC_CONVERT && tick) begin
            rises <= rises + 6'h01;
        end
    end

    sequence s_setup_write;
        take_wr && idx == `AAC_IDX_SETUP;
    endsequence

    sequence s_srst_rise;
        take_wr && idx == `AAC_IDX_CTRL0 && wb_dat_i[`AAC_CTRL0_SRST] && !srst_bit;
    endsequence

    a_conv_length: assert property ($rose(done) |-> rises == conv_len(cfg_len)) // see RULE_13
        else $error("conversion did not last the configured cycles");

    a_start_clears: assert property (s_setup_write |=> // see RULE_03
        !done && conversion_start_o && state == AAC_CONVERT ##1 !conversion_start_o)
        else $error("setup write did not start a conversion");

    a_result_high: assert property (take_rd && idx == `AAC_IDX_RES_HI |-> // see RULE_04
        wb_dat_o == {24'h000000, $past(result[`AAC_RESHI_RES])})
        else $error("result high read mismatch");

    a_result_low: assert property (take_rd && idx == `AAC_IDX_RES_LO |-> // see RULE_05
        wb_dat_o[7:0] == {$past(result[`AAC_RESLO_RES]), $past(done), $past(echo)})
        else $error("result low status read mismatch");

    a_capture_together: assert property ($rose(done) |-> // see RULE_17
        echo == $past(input_channel_select_o) && result == $past(conversion_result_i))
        else $error("result and channel echo not captured together");

    a_clock_gate: assert property (!clk_en [*2] |-> !converter_clock_o) // see RULE_08
        else $error("converter clock runs while disabled");

    a_srst_edge: assert property (s_srst_rise |=> converter_reset_o ##1 !converter_reset_o) // see RULE_09
        else $error("soft reset edge gave no single pulse");

    a_srst_level: assert property ($past(srst_bit) && srst_bit |-> !converter_reset_o) // see RULE_09
        else $error("held soft reset bit retriggered the reset");

    a_sensor_trim: assert property (take_wr && idx == `AAC_IDX_CTRL1 |=> // see RULE_14
        temp_sensor_enable_o == $past(wb_dat_i[`AAC_CTRL1_TEMP]) &&
        reference_trim_o == $past(wb_dat_i[`AAC_CTRL1_TRIM])) // see RULE_15
        else $error("sensor enable or trim not taken from write");

    a_unused_zero: assert property (take_rd |-> wb_dat_o[31:8] == 24'h000000 && // see RULE_18
        (idx != `AAC_IDX_CTRL0 || wb_dat_o[5:3] == 3'h0))
        else $error("unused bits read nonzero");

endmodule // aac_ctrl

`default_nettype wire

//--- shared/aac_cfg.svh
/*
 * Register map, field positions, reset values and conversion lengths of the
 * auxiliary converter sequencer.
 * Assumes it is included by bare name wherever a constant below is needed.
 */
`ifndef AAC_CFG_SVH
`define AAC_CFG_SVH

// =============================================================================
// Register indices; the byte address on the bus is four times the index.
`define AAC_IDX_SETUP 8'h77
`define AAC_IDX_RES_HI 8'h78
`define AAC_IDX_RES_LO 8'h79
`define AAC_IDX_CTRL0 8'h7A
`define AAC_IDX_CTRL1 8'h7B
`define AAC_IDX_IRQ_STAT 8'h90
`define AAC_IDX_IRQ_MASK 8'h91

// =============================================================================
// Field positions.
`define AAC_SETUP_LEN 7:6
`define AAC_SETUP_CH 2:0
`define AAC_RESHI_RES 11:4
`define AAC_RESLO_RES 3:0
`define AAC_CTRL0_CLKEN 7
`define AAC_CTRL0_SRST 6
`define AAC_CTRL0_DIV 2:0
`define AAC_CTRL1_TEMP 7
`define AAC_CTRL1_TRIM 4:2
`define AAC_IRQ_DONE 0
`define AAC_IRQ_SRST 1
`define AAC_IRQ_W 2

// =============================================================================
// Reset values.
`define AAC_RST_LEN 2'h0
`define AAC_RST_CH 3'h0
`define AAC_RST_DIV 3'h0
`define AAC_RST_TRIM 3'h0
`define AAC_RST_RESULT 12'h000
`define AAC_RST_IRQ 2'h0

// =============================================================================
// Conversion lengths in converter clock cycles, by length code.
`define AAC_LEN_0 6'h14
`define AAC_LEN_1 6'h16
`define AAC_LEN_2 6'h1A
`define AAC_LEN_3 6'h22

// Divide ratio is two to the power (this exponent plus one minus the code).
`define AAC_DIV_EXP 3'h7

`endif

//--- shared/aac_pkg.sv
/*
 * Types shared by the auxiliary converter sequencer modules.
 * Assumes nothing of its surroundings.
 */
package aac_pkg;

    typedef enum logic {
        AAC_IDLE,
        AAC_CONVERT
    } aac_state_t;

    typedef logic [2:0] aac_chan_t;

    typedef logic [11:0] aac_result_t;

endpackage
